/* File: inc/frt_cfg.svh */
// offsets, fields, codes and limits of the rounding slice
`ifndef FRT_CFG_SVH
`define FRT_CFG_SVH
`define FRT_MAJOR 6'h15
`define FRT_GROUP 6'h3B
`define FRT_MIN_LONG 8'hCC
`define FRT_MIN_WORD 8'hEC
`define FRT_MIN_RSQ 8'h08
`define FRT_FMT_BIT 14
`define FRT_ZERO_BIT 15
`define FRT_A_CTRL 12'h000
`define FRT_A_STAT 12'h004
`define FRT_A_CLR 12'h008
`define FRT_A_EN 12'h00C
`define FRT_C_NAN 8
`define FRT_C_FRM 9
`define FRT_C_F64 10
`define FRT_F_INX 0
`define FRT_F_UNI 1
`define FRT_F_INV 2
`define FRT_F_DZ 3
`define FRT_LONG_LIM 67'h7FFF_FFFF_FFFF_FFFF
`define FRT_WORD_LIM 67'h7FFF_FFFF
`define FRT_LONG_MAX 64'h7FFF_FFFF_FFFF_FFFF
`define FRT_WORD_MAX 32'h7FFF_FFFF
`define FRT_LONG_NEG 64'h8000_0000_0000_0001
`define FRT_WORD_NEG 32'h8000_0001
`define FRT_D_QNAN 64'h7FF8_0000_0000_0000
`define FRT_S_QNAN 32'h7FC0_0000
`define FRT_D_INF 63'h7FF0_0000_0000_0000
`define FRT_S_INF 31'h7F80_0000
`define FRT_D_BIAS 13'h03FF
`define FRT_S_BIAS 13'h007F
`define FRT_SQ_CNT 6'h38
`define FRT_DV_CNT 6'h37
`define FRT_DV_INIT 57'h80_0000_0000_0000
`endif

/* File: inc/frt_pkg.sv */
// types of the rounding slice
package frt_pkg;
    typedef enum logic [1:0] {
        frt_st_idle = 2'b00,
        frt_st_cvt = 2'b01,
        frt_st_rsq = 2'b10
    } frt_state_t;
    typedef enum logic [1:0] {
        frt_rq_idle = 2'b00,
        frt_rq_sqrt = 2'b01,
        frt_rq_div = 2'b10,
        frt_rq_pack = 2'b11
    } frt_rq_state_t;
    typedef enum logic [1:0] {
        frt_exc_none = 2'b00,
        frt_exc_cu = 2'b01,
        frt_exc_ri = 2'b10,
        frt_exc_fpe = 2'b11
    } frt_exc_t;
endpackage

/* File: inc/frt_rsq_if.sv */
// operand and answer bundle between slice and recip_sqrt_approx engine
`timescale 1ns/1ns
`default_nettype none
interface frt_rsq_if;
    logic start, dbl, sign, is_zero, is_sub, is_inf, is_nan, is_snan;
    logic signed [12:0] expo;
    logic [52:0] mant;
    logic done;
    logic [63:0] res;
    logic [5:0] cause;
    modport ctl (output start, dbl, sign, is_zero, is_sub, is_inf, is_nan,
        is_snan, expo, mant, input done, res, cause);
    modport eng (input start, dbl, sign, is_zero, is_sub, is_inf, is_nan,
        is_snan, expo, mant, output done, res, cause);
endinterface
`default_nettype wire

/* File: design/frt_unpack.sv */
// splits a single or double operand into sign, exponent, mantissa, class
`timescale 1ns/1ns
`default_nettype none
`include "frt_cfg.svh"
module frt_unpack (
    input wire logic [63:0] word,
    input wire logic dbl,
    output logic sign,
    output logic signed [12:0] expo,
    output logic [52:0] mant,
    output logic is_zero,
    output logic is_sub,
    output logic is_inf,
    output logic is_nan,
    output logic is_snan
);
    // single fraction widened so one datapath serves both formats
    wire [10:0] ex = dbl ? word[62:52] : {3'h0, word[30:23]};
    wire [51:0] fr = dbl ? word[51:0] : {word[22:0], 29'h0};
    wire [10:0] ex_top = dbl ? 11'h7FF : 11'h0FF;
    wire [12:0] bias = dbl ? `FRT_D_BIAS : `FRT_S_BIAS;
    wire ex_z = ex == 11'h0;
    wire ex_o = ex == ex_top;
    assign sign = dbl ? word[63] : word[31];
    // subnormals share the smallest normal exponent
    assign expo = ex_z ? 13'h1 - bias : {2'h0, ex} - bias;
    assign mant = {~ex_z, fr};
    assign is_zero = ex_z & (fr == 52'h0);
    assign is_sub = ex_z & (fr != 52'h0);
    assign is_inf = ex_o & (fr == 52'h0);
    assign is_nan = ex_o & (fr != 52'h0);
    // quiet bit set means quiet nan
    assign is_snan = is_nan & ~fr[51];
endmodule
`default_nettype wire

/* File: design/frt_rsq.sv */
// iterative reciprocal square root: digit sqrt then restoring divide
`timescale 1ns/1ns
`default_nettype none
`include "frt_cfg.svh"
module frt_rsq (
    input wire logic clk,
    input wire logic rst_n,
    frt_rsq_if.eng rq
);
    frt_pkg::frt_rq_state_t st_ff, nxt_st;
    logic [113:0] rad_ff;
    logic [58:0] rem_ff;
    logic [56:0] root_ff, drem_ff;
    logic [55:0] q_ff;
    logic [5:0] cnt_ff;
    logic signed [12:0] half_ff;
    logic dbl_ff, done_ff;
    logic [63:0] res_ff;
    logic [5:0] cause_ff;
    // odd exponent folds into the mantissa so the root exponent halves
    wire odd = rq.expo[0];
    wire [53:0] mp = odd ? {rq.mant, 1'b0} : {1'b0, rq.mant};
    wire signed [12:0] e_even = rq.expo - {12'h0, odd};
    wire [60:0] rem2 = {rem_ff, rad_ff[113:112]};
    wire [60:0] trial = {2'h0, root_ff, 2'h1};
    wire sq_ge = rem2 >= trial;
    wire [60:0] rem_sub = rem2 - trial;
    wire [57:0] d2 = {drem_ff, 1'b0};
    wire dv_ge = d2 >= {1'b0, root_ff};
    wire [57:0] d_sub = d2 - {1'b0, root_ff};
    // quotient of exactly two means the mantissa was one
    wire one = q_ff[55];
    wire signed [12:0] rexp = one ? -half_ff : -half_ff - 13'sd1;
    wire [12:0] bexp = rexp + (dbl_ff ? `FRT_D_BIAS : `FRT_S_BIAS);
    wire [51:0] frac = one ? 52'h0 : q_ff[53:2];
    // truncation everywhere: rounding mode never applies, error under 2 ulp
    wire pk_inx = (|rem_ff) | (|drem_ff) | (dbl_ff ? |q_ff[1:0] : |q_ff[30:0]); // RULE14
    wire [63:0] pk_res = dbl_ff ? {1'b0, bexp[10:0], frac} // RULE13
        : {32'h0, 1'b0, bexp[7:0], frac[51:29]};
    // specials finish at once
    wire neg = rq.sign & ~rq.is_zero & ~rq.is_nan;
    wire sp = rq.is_nan | rq.is_inf | rq.is_zero | rq.is_sub | rq.sign;
    wire [63:0] qnan = rq.dbl ? `FRT_D_QNAN : {32'h0, `FRT_S_QNAN};
    wire [63:0] sinf = rq.dbl ? {rq.sign, `FRT_D_INF} : {32'h0, rq.sign, `FRT_S_INF};
    wire [63:0] sp_res = (rq.is_nan | (neg & ~rq.is_sub)) ? qnan
        : rq.is_zero ? sinf : 64'h0;
    wire sp_inv = rq.is_snan | (neg & ~rq.is_sub); // RULE16
    wire [5:0] sp_cause = {2'h0, rq.is_zero, sp_inv, rq.is_sub, 1'b0}; // RULE16
    assign rq.done = done_ff;
    assign rq.res = res_ff;
    assign rq.cause = cause_ff;
    // sequencing
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            frt_pkg::frt_rq_idle: if (rq.start && !sp) nxt_st = frt_pkg::frt_rq_sqrt;
            frt_pkg::frt_rq_sqrt: if (cnt_ff == 6'h0) nxt_st = frt_pkg::frt_rq_div;
            frt_pkg::frt_rq_div: if (cnt_ff == 6'h0) nxt_st = frt_pkg::frt_rq_pack;
            default: nxt_st = frt_pkg::frt_rq_idle;
        endcase
    end
    // datapath steps one digit per clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= frt_pkg::frt_rq_idle;
            {rad_ff, rem_ff, root_ff, drem_ff, q_ff, cnt_ff} <= '0;
            {half_ff, dbl_ff, done_ff, res_ff, cause_ff} <= '0;
        end else begin
            st_ff <= nxt_st;
            done_ff <= 1'b0;
            case (st_ff)
                frt_pkg::frt_rq_idle: if (rq.start) begin
                    done_ff <= sp;
                    res_ff <= sp_res;
                    cause_ff <= sp_cause;
                    rad_ff <= {mp, 60'h0};
                    {rem_ff, root_ff} <= '0;
                    cnt_ff <= `FRT_SQ_CNT;
                    half_ff <= e_even >>> 1;
                    dbl_ff <= rq.dbl;
                end
                frt_pkg::frt_rq_sqrt: begin
                    rem_ff <= sq_ge ? rem_sub[58:0] : rem2[58:0];
                    root_ff <= {root_ff[55:0], sq_ge};
                    rad_ff <= {rad_ff[111:0], 2'h0};
                    cnt_ff <= (cnt_ff == 6'h0) ? `FRT_DV_CNT : cnt_ff - 6'h1;
                    drem_ff <= `FRT_DV_INIT;
                    q_ff <= '0;
                end
                frt_pkg::frt_rq_div: begin
                    drem_ff <= dv_ge ? d_sub[56:0] : d2[56:0];
                    q_ff <= {q_ff[54:0], dv_ge};
                    cnt_ff <= cnt_ff - 6'h1;
                end
                default: begin
                    done_ff <= 1'b1;
                    res_ff <= pk_res;
                    cause_ff <= {5'h0, pk_inx};
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: design/frt_top.sv */
// fp round-to-fixed and reciprocal sqrt slice with apb control
// Function
// RULE1: long convert rounds nearest even always
// RULE2: word convert rounds nearest even, writes dest
// RULE3: long invalid on inf, nan, out of range
// RULE4: word invalid on inf, nan, out of range
// RULE5: invalid condition sets invalid flag
// RULE6: trap enabled: no write, exception now
// RULE7: legacy nan mode default is positive max
// RULE8: 2008 mode: nan zero, signed limits; the negative default here is 0x8000_0001, long 0x8000_0000_0000_0001
// RULE9: long result valid only 64-bit wide mode
// RULE10: conversions raise cu, ri, fp exceptions
// RULE11: word opcode decode 0xEC, group 0x3B
// RULE12: long opcode decode 0xCC, same group
// RULE13: recip_sqrt_approx within two ulp
// RULE14: recip_sqrt_approx ignores rounding mode consistently
// RULE15: recip_sqrt_approx opcode decode 0x08, group 0x3B
// RULE16: recip_sqrt_approx raises its six fp exceptions; the engine sets only cause bits 3:0, never bits 5:4
// RULE17: bit 14 picks single or double
// RULE18: bad operand gives any result, no hang
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "frt_cfg.svh"
module frt_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] src_operand,
    input wire logic cop_usable,
    output logic instr_ready,
    output logic op_done,
    output logic fpr_wr_en,
    output logic [4:0] fpr_wr_idx,
    output logic [63:0] fpr_wr_data,
    output logic exc_take,
    output logic [1:0] exc_code,
    output logic [5:0] fp_cause,
    output logic irq,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // reset release synchroniser
    logic rst_meta_ff, rst_sync_ff;
    wire rst_core_n = rst_sync_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // software state
    logic [10:0] ctrl_ff; // trap enables, nan mode, width mode
    logic [5:0] stat_ff; // sticky fp flags
    logic [5:0] en_ff; // interrupt enables
    logic irq_ff;

    // apb slave answer registers
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;

    // instruction side state
    frt_pkg::frt_state_t st_ff, nxt_st;
    logic [63:0] opnd_ff; // latched source value
    logic dbl_ff; // double source
    logic lng_ff; // long target
    logic ready_ff, done_ff, wr_en_ff, exc_ff, start_ff;
    logic [4:0] idx_ff;
    logic [63:0] wdata_ff;
    logic [1:0] code_ff;
    logic [5:0] cause_ff;

    // ---- apb decode ----
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite & pready_ff;
    wire a_ctrl = paddr == `FRT_A_CTRL;
    wire a_stat = paddr == `FRT_A_STAT;
    wire a_clr = paddr == `FRT_A_CLR;
    wire a_en = paddr == `FRT_A_EN;
    wire a_hit = a_ctrl | a_stat | a_clr | a_en;
    // clear register is write only; reads give zero
    wire [31:0] rd_mux = a_ctrl ? {21'h0, ctrl_ff}
        : a_stat ? {26'h0, stat_ff}
        : a_en ? {26'h0, en_ff}
        : 32'h0;
    wire [5:0] clr_bits = (apb_wr & a_clr) ? pwdata[5:0] : 6'h0;

    // one wait-free access: answer registered during setup
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~a_hit;
            prdata_ff <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // control and enable writes
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ctrl_ff <= 11'h0;
            en_ff <= 6'h0;
        end else begin
            if (apb_wr && a_ctrl) begin
                ctrl_ff <= pwdata[10:0];
            end
            if (apb_wr && a_en) begin
                en_ff <= pwdata[5:0];
            end
        end
    end

    wire [5:0] trap_en = ctrl_ff[5:0];
    wire nan_encoding_select = ctrl_ff[`FRT_C_NAN];
    wire wide_mode = ctrl_ff[`FRT_C_FRM];
    wire fpu64 = ctrl_ff[`FRT_C_F64];

    // ---- instruction decode ----
    wire [7:0] minor = instr_word[13:6];
    wire group_hit = (instr_word[31:26] == `FRT_MAJOR)
        & (instr_word[5:0] == `FRT_GROUP)
        & ~instr_word[`FRT_ZERO_BIT];
    wire is_word = group_hit & (minor == `FRT_MIN_WORD); // RULE11
    wire is_long = group_hit & (minor == `FRT_MIN_LONG); // RULE12
    wire is_rsq = group_hit & (minor == `FRT_MIN_RSQ); // RULE15
    wire op_hit = is_word | is_long | is_rsq;
    wire accept = instr_valid & ready_ff;
    // coprocessor check ranks ahead of decode
    wire bad_cu = accept & ~cop_usable; // RULE10
    wire bad_ri = accept & cop_usable & ~op_hit; // RULE10
    wire go = accept & cop_usable & op_hit;

    // ---- operand unpack ----
    frt_rsq_if rq ();
    logic up_sign, up_zero, up_sub, up_inf, up_nan, up_snan;
    logic signed [12:0] up_e;
    logic [52:0] up_mant;

    frt_unpack u_unpack (
        .word(opnd_ff),
        .dbl(dbl_ff),
        .sign(up_sign),
        .expo(up_e),
        .mant(up_mant),
        .is_zero(up_zero),
        .is_sub(up_sub),
        .is_inf(up_inf),
        .is_nan(up_nan),
        .is_snan(up_snan)
    );

    // same unpacked fields feed the recip_sqrt_approx engine
    assign rq.start = start_ff;
    assign rq.dbl = dbl_ff;
    assign rq.sign = up_sign;
    assign rq.expo = up_e;
    assign rq.mant = up_mant;
    assign rq.is_zero = up_zero;
    assign rq.is_sub = up_sub;
    assign rq.is_inf = up_inf;
    assign rq.is_nan = up_nan;
    assign rq.is_snan = up_snan;

    frt_rsq u_rsq (
        .clk(mclk),
        .rst_n(rst_core_n),
        .rq(rq.eng)
    );

    // ---- conversion datapath ----
    // value times 2^54 lands the binary point at bit 54
    wire signed [12:0] sh_s = up_e + 13'sd2;
    wire cv_small = up_e < -13'sd2; // below a quarter
    wire cv_big = up_e > 13'sd63; // also inf and nan
    wire [119:0] cv_wide = {67'h0, up_mant} << sh_s[6:0];
    wire [65:0] cv_int = cv_wide[119:54];
    wire cv_grd = cv_wide[53];
    wire cv_stk = |cv_wide[52:0];
    // ties go to the even integer; rounding mode never consulted
    wire cv_up = cv_grd & (cv_stk | cv_int[0]); // RULE1 RULE2
    wire [66:0] cv_mag = cv_small ? 67'h0
        : {1'b0, cv_int} + {66'h0, cv_up};
    // negative side reaches one further than positive
    wire [66:0] cv_lim = lng_ff ? `FRT_LONG_LIM : `FRT_WORD_LIM;
    wire cv_ovf = cv_big | (cv_mag > cv_lim + {66'h0, up_sign});
    wire cv_inv = up_nan | up_inf | cv_ovf; // RULE3 RULE4
    wire [63:0] cv_sv = up_sign ? 64'h0 - cv_mag[63:0] : cv_mag[63:0];
    wire [63:0] cv_val = lng_ff ? cv_sv : {32'h0, cv_sv[31:0]};
    wire [63:0] cv_max = lng_ff ? `FRT_LONG_MAX : {32'h0, `FRT_WORD_MAX};
    wire [63:0] cv_neg = lng_ff ? `FRT_LONG_NEG : {32'h0, `FRT_WORD_NEG};
    // legacy mode saturates everything to the positive maximum
    wire [63:0] cv_dflt = ~nan_encoding_select ? cv_max // RULE7
        : up_nan ? 64'h0 // RULE8
        : up_sign ? cv_neg : cv_max; // RULE8
    wire [63:0] cv_res = cv_inv ? cv_dflt : cv_val;
    wire cv_inx = ~cv_inv & (cv_small ? ~up_zero : (cv_grd | cv_stk));
    wire [5:0] cv_cause = {3'h0, cv_inv, 1'b0, cv_inx}; // RULE5 RULE10

    // long result in narrow register mode is simply what the wide path gives
    wire narrow_long = lng_ff & ~(wide_mode & fpu64); // RULE9

    // ---- completion ----
    wire fin_cvt = st_ff == frt_pkg::frt_st_cvt;
    wire fin_rsq = (st_ff == frt_pkg::frt_st_rsq) & rq.done;
    wire fin = fin_cvt | fin_rsq;
    wire [63:0] fin_res = fin_cvt ? cv_res : rq.res;
    wire [5:0] fin_cause = fin_cvt ? cv_cause : rq.cause;
    // unimplemented operation always traps
    wire fin_trap = (|(fin_cause & trap_en)) | fin_cause[`FRT_F_UNI]; // RULE6
    wire [5:0] set_bits = fin ? fin_cause : 6'h0;

    // ---- sequencing ----
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            frt_pkg::frt_st_idle: begin
                if (go) begin
                    nxt_st = is_rsq ? frt_pkg::frt_st_rsq : frt_pkg::frt_st_cvt;
                end
            end
            frt_pkg::frt_st_cvt: nxt_st = frt_pkg::frt_st_idle;
            frt_pkg::frt_st_rsq: begin
                // engine always finishes, even on bad operands
                if (rq.done) begin
                    nxt_st = frt_pkg::frt_st_idle; // RULE18
                end
            end
            default: nxt_st = frt_pkg::frt_st_idle;
        endcase
    end

    // state and operand capture
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_ff <= frt_pkg::frt_st_idle;
            opnd_ff <= 64'h0;
            dbl_ff <= 1'b0;
            lng_ff <= 1'b0;
            idx_ff <= 5'h0;
            start_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            start_ff <= go & is_rsq;
            if (go) begin
                opnd_ff <= src_operand;
                dbl_ff <= instr_word[`FRT_FMT_BIT]; // RULE17
                lng_ff <= is_long;
                idx_ff <= instr_word[25:21];
            end
        end
    end

    // ---- result and exception outputs ----
    wire nxt_ready = nxt_st == frt_pkg::frt_st_idle;
    wire nxt_wr_en = fin & ~fin_trap; // RULE6
    wire nxt_exc = bad_cu | bad_ri | (fin & fin_trap); // RULE6 RULE10
    wire [1:0] nxt_code = bad_cu ? frt_pkg::frt_exc_cu
        : bad_ri ? frt_pkg::frt_exc_ri
        : (fin & fin_trap) ? frt_pkg::frt_exc_fpe
        : frt_pkg::frt_exc_none;

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            wr_en_ff <= 1'b0;
            wdata_ff <= 64'h0;
            exc_ff <= 1'b0;
            code_ff <= 2'h0;
            cause_ff <= 6'h0;
        end else begin
            ready_ff <= nxt_ready;
            done_ff <= fin | bad_cu | bad_ri;
            wr_en_ff <= nxt_wr_en; // RULE2
            wdata_ff <= nxt_wr_en ? fin_res : 64'h0;
            exc_ff <= nxt_exc;
            code_ff <= nxt_code;
            cause_ff <= set_bits;
        end
    end

    // sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stat_ff <= 6'h0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~clr_bits) | set_bits; // RULE5
            irq_ff <= |(((stat_ff & ~clr_bits) | set_bits) & en_ff);
        end
    end

    // ---- ports ----
    assign instr_ready = ready_ff;
    assign op_done = done_ff;
    assign fpr_wr_en = wr_en_ff;
    assign fpr_wr_idx = idx_ff;
    assign fpr_wr_data = wdata_ff;
    assign exc_take = exc_ff;
    assign exc_code = code_ff;
    assign fp_cause = cause_ff;
    assign irq = irq_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

endmodule
`default_nettype wire

/* File: verif/frt_top_monitor.sv */
// concurrent checks on the slice's instruction and apb ports
`timescale 1ns/1ns
`default_nettype none
module frt_top_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic cop_usable,
    input wire logic instr_ready,
    input wire logic op_done,
    input wire logic fpr_wr_en,
    input wire logic exc_take,
    input wire logic [1:0] exc_code,
    input wire logic [5:0] fp_cause,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // decode of the accepted request
    wire take = instr_valid && instr_ready;
    wire [7:0] minor = instr_word[13:6];
    wire grp_ok = instr_word[31:26] == 6'h15 && instr_word[5:0] == 6'h3B && !instr_word[15];
    wire cvt = minor == 8'hCC || minor == 8'hEC;
    wire rsq = minor == 8'h08;
    // apb setup and address map, four aligned words
    wire setup = psel && !penable;
    wire mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
    sequence s_cvt_take;
        take && cop_usable && grp_ok && cvt;
    endsequence
    sequence s_cvt_answer;
        !op_done ##1 op_done;
    endsequence
    a_cvt_latency: assert property (s_cvt_take |=> s_cvt_answer)
        else $error("conversion answer not two cycles after accept");
    a_busy_after_take: assert property (s_cvt_take or (take && cop_usable && grp_ok && rsq) |=> !instr_ready)
        else $error("ready stayed high after accept");
    a_cu_refuse: assert property (take && !cop_usable |=> exc_take && exc_code == 2'h1)
        else $error("coprocessor unusable not refused next cycle");
    a_ri_refuse: assert property (take && cop_usable && grp_ok && !cvt && !rsq
        |=> exc_take && exc_code == 2'h2) else $error("reserved minor not refused");
    a_trap_no_write: assert property (exc_take |-> !fpr_wr_en)
        else $error("write together with exception");
    a_write_pulse: assert property (fpr_wr_en |-> op_done ##1 !fpr_wr_en)
        else $error("write not a single pulse with done");
    a_done_ready: assert property (op_done |-> instr_ready)
        else $error("done without ready");
    a_cause_done: assert property (fp_cause != 6'h00 |-> op_done)
        else $error("cause outside done");
    a_apb_answer: assert property (setup |=> pready && penable)
        else $error("apb access not answered at once");
    a_apb_unmapped: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access without error");
endmodule
bind frt_top frt_top_monitor u_frt_top_monitor (.*);
`default_nettype wire

/* File: verif/frt_fpr_model.sv */
// far side model: fp register file fed by the slice's write port
`timescale 1ns/1ns
`default_nettype none
module frt_fpr_model (
    input wire logic mclk,
    input wire logic fpr_wr_en,
    input wire logic [4:0] fpr_wr_idx,
    input wire logic [63:0] fpr_wr_data,
    input wire logic [4:0] rd_idx,
    output logic [63:0] rd_data
);
    logic [63:0] fpr_ff [32]; // register contents, unknown until written
    // only the write pulse lands, so a trapped op leaves the entry alone
    always_ff @(posedge mclk) begin
        if (fpr_wr_en) begin
            fpr_ff[fpr_wr_idx] <= fpr_wr_data;
        end
    end
    assign rd_data = fpr_ff[rd_idx]; // read side for the bench
endmodule
`default_nettype wire

/* File: verif/test_frt_top.sv */
// self-checking bench for the rounding slice
`timescale 1ns/1ns
`default_nettype none
`include "frt_cfg.svh"
module test_frt_top;
    logic mclk = 1'h0, rst_n = 1'h0, instr_valid = 1'h0, cop_usable = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] instr_word = '0, pwdata = '0, prdata, rd;
    logic [63:0] src_operand = '0, fpr_wr_data, q, rd_data;
    logic [11:0] paddr = '0;
    logic instr_ready, op_done, fpr_wr_en, exc_take, irq, pready, pslverr, w, e;
    logic [4:0] fpr_wr_idx;
    logic [1:0] exc_code, c;
    logic [5:0] fp_cause, f;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    always #10 mclk = ~mclk; // 50 MHz
    frt_top u_frt_top (.*);
    frt_fpr_model u_frt_fpr_model (.*, .rd_idx(5'h07));
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, far above the expected run
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, ex, got);
        end
    endtask
    // one apb transfer; answer taken at the edge where pready is seen
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (!pready);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // issue one instruction, dest 7, and capture the one-cycle answer
    task op(input logic [7:0] mn, input logic dbl, input logic [63:0] s);
        @(posedge mclk);
        instr_valid <= 1'h1;
        instr_word <= {`FRT_MAJOR, 5'h07, 5'h03, 1'b0, dbl, mn, `FRT_GROUP};
        src_operand <= s;
        do @(posedge mclk); while (!instr_ready);
        instr_valid <= 1'h0;
        do @(posedge mclk); while (!op_done);
        chk("op_done", 1, op_done);
        w = fpr_wr_en;
        q = fpr_wr_data;
        c = exc_code;
        f = fp_cause;
    endtask
    task run(input logic [7:0] mn, input logic dbl, input logic [63:0] s, input logic [63:0] x);
        op(mn, dbl, s);
        chk("write", 1, w);
        chk("result", x, q);
    endtask
    task t_regs();
        apb(0, `FRT_A_CTRL, 0);
        chk("ctrl", 0, rd);
        apb(0, `FRT_A_STAT, 0);
        chk("status", 0, rd);
        apb(0, 12'h010, 0);
        chk("slverr", 1, e);
        $display("registers done");
    endtask
    task t_round();
        run(`FRT_MIN_WORD, 1, 64'h4004_0000_0000_0000, 64'h2);
        chk("cause", 1, f);
        run(`FRT_MIN_WORD, 1, 64'h400C_0000_0000_0000, 64'h4);
        run(`FRT_MIN_WORD, 0, 64'hC020_0000, 64'hFFFF_FFFE);
        run(`FRT_MIN_LONG, 1, 64'hC00C_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFC);
        run(`FRT_MIN_LONG, 0, 64'h4020_0000, 64'h2);
        @(posedge mclk);
        chk("model", 64'h2, rd_data);
        $display("rounding done");
    endtask
    task t_legacy();
        run(`FRT_MIN_WORD, 0, 64'h7F80_0000, 64'h7FFF_FFFF);
        chk("invalid", 1, f[2]);
        run(`FRT_MIN_WORD, 1, 64'h41E0_0000_0000_0000, 64'h7FFF_FFFF);
        run(`FRT_MIN_WORD, 1, 64'hC1E0_0000_0000_0000, 64'h8000_0000);
        run(`FRT_MIN_LONG, 1, 64'h7FF8_0000_0000_0000, 64'h7FFF_FFFF_FFFF_FFFF);
        apb(0, `FRT_A_STAT, 0);
        chk("flag", 1, rd[2]);
        $display("legacy defaults done");
    endtask
    task t_2008();
        apb(1, `FRT_A_CTRL, 32'h0000_0100);
        run(`FRT_MIN_WORD, 1, 64'h7FF8_0000_0000_0000, 64'h0);
        run(`FRT_MIN_WORD, 0, 64'hFF80_0000, 64'h8000_0001);
        run(`FRT_MIN_LONG, 1, 64'hFFF0_0000_0000_0000, 64'h8000_0000_0000_0001);
        run(`FRT_MIN_LONG, 1, 64'h43E0_0000_0000_0000, 64'h7FFF_FFFF_FFFF_FFFF);
        run(`FRT_MIN_LONG, 1, 64'hC3E0_0000_0000_0000, 64'h8000_0000_0000_0000);
        apb(1, `FRT_A_CTRL, 0);
        $display("2008 defaults done");
    endtask
    task t_trap();
        apb(1, `FRT_A_CLR, 32'h0000_003F);
        apb(1, `FRT_A_EN, 32'h0000_0004);
        apb(1, `FRT_A_CTRL, 32'h0000_0004);
        op(`FRT_MIN_WORD, 0, 64'h7F80_0000);
        chk("irq", 1, irq);
        chk("write", 0, w);
        chk("code", 3, c);
        chk("model", 64'h8000_0000_0000_0000, rd_data);
        apb(0, `FRT_A_STAT, 0);
        chk("status", 4, rd);
        apb(1, `FRT_A_CLR, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        chk("irq", 0, irq);
        apb(1, `FRT_A_CTRL, 0);
        $display("trap done");
    endtask
    task t_exc();
        cop_usable <= 1'h0;
        op(`FRT_MIN_WORD, 1, 64'h0);
        chk("code", 1, c);
        cop_usable <= 1'h1;
        op(8'hFF, 1, 64'h0);
        chk("code", 2, c);
        $display("refusals done");
    endtask
    task t_rsq();
        op(`FRT_MIN_RSQ, 1, 64'h4010_0000_0000_0000);
        chk("rsq_d", 1, (q - 64'h3FE0_0000_0000_0000 + 64'h2) <= 64'h4);
        op(`FRT_MIN_RSQ, 0, 64'h4080_0000);
        chk("rsq_s", 1, (q - 64'h3F00_0000 + 64'h2) <= 64'h4);
        op(`FRT_MIN_RSQ, 1, 64'h0);
        chk("divzero", 1, f[3]);
        chk("rsq_inf", 64'h7FF0_0000_0000_0000, q);
        $display("recip_sqrt_approx done");
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (4) @(posedge mclk);
        t_regs();
        t_round();
        t_legacy();
        t_2008();
        t_trap();
        t_exc();
        t_rsq();
        end_sim();
    end
endmodule
`default_nettype wire
